// *** include/phy_strap_defs.svh ***
// Offsets, field positions, reset values and limits of the strap merge block
// What this block does
// - Autonegotiation is on only while its strap and control bit 12 are both high.
// - A pulse on the autonegotiation strap restarts autonegotiation.
// - Full duplex is the OR of its strap and control bit 8, and is ignored while autonegotiation is on.
// - Carrier sense follows receive activity only when its strap or bit 10 of register 29 is high.
// - Serial interface mode is on when its strap or bit 1 of register 30 is high.
// - The carrier integrity monitor is on when its strap or bit 3 of register 29 is high.
// - The encoder and decoder are bypassed when their strap or bit 6 of register 29 is high.
// - The scrambler and descrambler are bypassed when their strap or bit 4 of register 29 is high.
// - 100 Mbit/s needs both the speed strap and control bit 13, and is ignored while autonegotiation is on.
// - The station address comes from a five-bit strap and address zero is no broadcast.
// - Fiber mode is on when its strap or bit 0 of register 29 is high.
// - Timer test input is low in normal use; when high the timers run faster by the selected factor.
// - Speedup select gives factors 1, 16, 64 and 256 for codes 00, 01, 10 and 11.
// - With enhanced link check on, the link drops after 31 Manchester violations.
`ifndef PHY_STRAP_DEFS_SVH
`define PHY_STRAP_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 5'h00
`define REG_CFG29 5'h1d
`define REG_CFG30 5'h1e
`define REG_STATUS 5'h1f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_SPEED_BIT 13
`define CTRL_AUTONEG_BIT 12
`define CTRL_DUPLEX_BIT 8
`define CFG29_CRS_BIT 10
`define CFG29_CODEC_BIT 6
`define CFG29_SCRAMBLER_BIT 4
`define CFG29_CARRIER_BIT 3
`define CFG29_FIBER_BIT 0
`define CFG30_SERIAL_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET 16'h3000
`define CFG29_RESET 16'h0000
`define CFG30_RESET 16'h0000

// ----------------------------------------
// Limits and factors
// ----------------------------------------
`define VIOL_LAST 5'h1e
`define SCALE_X1 9'h001
`define SCALE_X16 9'h010
`define SCALE_X64 9'h040
`define SCALE_X256 9'h100
`define WARM_DONE 3'h5

`endif

// *** include/phy_strap_pkg.sv ***
// Types shared by the strap merge block
package phy_strap_pkg;

    typedef enum logic [1:0] {
        SPD_NONE = 2'b00,
        SPD_X16 = 2'b01,
        SPD_X64 = 2'b10,
        SPD_X256 = 2'b11
    } speedup_code_t;

    typedef enum logic [2:0] {
        LNK_DOWN = 3'b001,
        LNK_UP = 3'b010,
        LNK_TRIPPED = 3'b100
    } link_state_t;

endpackage : phy_strap_pkg

// *** core/strap_sync.sv ***
// Two-stage synchroniser for a group of strap levels
module strap_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage feeds only the second
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule : strap_sync

// *** core/phy_strap_config_merge.sv ***
// Merge of strap inputs with management bits into effective PHY settings
`include "phy_strap_defs.svh"

module phy_strap_config_merge
    import phy_strap_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Straps from surrounding logic
    input wire logic i_autoneg_strap,
    input wire logic i_full_duplex_strap,
    input wire logic i_carrier_sense_mode_strap,
    input wire logic i_serial_interface_strap,
    input wire logic i_carrier_integrity_strap,
    input wire logic i_codec_bypass_strap,
    input wire logic i_scrambler_bypass_strap,
    input wire logic i_speed_strap,
    input wire logic [4:0] i_station_address_strap,
    input wire logic i_fiber_select_strap,
    input wire logic i_timer_test_enable,
    input wire logic [1:0] i_timer_speedup_select,
    input wire logic i_enhanced_link_check_enable,
    // Same-clock link logic
    input wire logic i_link_raw,
    input wire logic i_manchester_violation,
    input wire logic [4:0] i_frame_phy_address,
    // Register port
    input wire logic [4:0] i_reg_addr,
    input wire logic [15:0] i_reg_wr_data,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rd_data,
    // Effective settings
    output logic o_autoneg_enable,
    output logic o_autoneg_restart,
    output logic o_full_duplex,
    output logic o_speed_100,
    output logic o_carrier_sense_rx_only,
    output logic o_serial_mode,
    output logic o_carrier_integrity_enable,
    output logic o_codec_bypass,
    output logic o_scrambler_bypass,
    output logic o_fiber_mode,
    output logic [4:0] o_station_address,
    output logic o_address_match,
    output logic [8:0] o_timer_scale,
    output logic o_autoneg_unsupported,
    output logic o_link_up
);

    // ----------------------------------------
    // Strap synchronisation
    // ----------------------------------------
    localparam int STRAP_W = 18;

    logic [STRAP_W-1:0] strap_raw;
    logic [STRAP_W-1:0] strap_sync;
    logic an_s;
    logic fdup_s;
    logic crs_s;
    logic ser_s;
    logic carin_s;
    logic codec_s;
    logic scr_s;
    logic speed_s;
    logic [4:0] addr_s;
    logic fiber_s;
    logic test_s;
    logic [1:0] sel_s;
    logic enh_s;

    assign strap_raw = {i_autoneg_strap, i_full_duplex_strap, i_carrier_sense_mode_strap,
                        i_serial_interface_strap, i_carrier_integrity_strap, i_codec_bypass_strap,
                        i_scrambler_bypass_strap, i_speed_strap, i_station_address_strap,
                        i_fiber_select_strap, i_timer_test_enable, i_timer_speedup_select,
                        i_enhanced_link_check_enable};

    strap_sync #(
        .WIDTH(STRAP_W)
    ) u_strap_sync (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_async(strap_raw),
        .o_sync(strap_sync)
    );

    assign {an_s, fdup_s, crs_s, ser_s, carin_s, codec_s, scr_s, speed_s, addr_s,
            fiber_s, test_s, sel_s, enh_s} = strap_sync;

    // ----------------------------------------
    // Management registers
    // ----------------------------------------
    logic [15:0] ctrl_r;
    logic [15:0] cfg29_r;
    logic [15:0] cfg30_r;
    logic [15:0] rd_data_r;
    logic [15:0] status_word;
    logic [15:0] rd_mux;
    logic sel_ctrl;
    logic sel_cfg29;
    logic sel_cfg30;
    logic sel_status;

    assign sel_ctrl = (i_reg_addr == `REG_CTRL);
    assign sel_cfg29 = (i_reg_addr == `REG_CFG29);
    assign sel_cfg30 = (i_reg_addr == `REG_CFG30);
    assign sel_status = (i_reg_addr == `REG_STATUS);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_r <= `CTRL_RESET;
            cfg29_r <= `CFG29_RESET;
            cfg30_r <= `CFG30_RESET;
        end else if (i_reg_wr) begin
            if (sel_ctrl) begin
                ctrl_r <= i_reg_wr_data;
            end else if (sel_cfg29) begin
                cfg29_r <= i_reg_wr_data;
            end else if (sel_cfg30) begin
                cfg30_r <= i_reg_wr_data;
            end
        end
    end

    // Unmapped offsets and the status word are read-only; writes there drop
    always_comb begin
        if (sel_ctrl) begin
            rd_mux = ctrl_r;
        end else if (sel_cfg29) begin
            rd_mux = cfg29_r;
        end else if (sel_cfg30) begin
            rd_mux = cfg30_r;
        end else if (sel_status) begin
            rd_mux = status_word;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rd_data_r <= 16'h0000;
        end else begin
            rd_data_r <= i_reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign o_reg_rd_data = rd_data_r;

    // ----------------------------------------
    // Setting merge
    // ----------------------------------------
    logic an_nxt;
    logic restart_nxt;
    logic fdup_nxt;
    logic speed_nxt;
    logic crs_nxt;
    logic ser_nxt;
    logic carin_nxt;
    logic codec_nxt;
    logic scr_nxt;
    logic fiber_nxt;
    logic an_d_r;

    assign an_nxt = an_s & ctrl_r[`CTRL_AUTONEG_BIT];
    assign restart_nxt = an_s & ~an_d_r;
    assign fdup_nxt = ~an_nxt & (fdup_s | ctrl_r[`CTRL_DUPLEX_BIT]);
    assign speed_nxt = ~an_nxt & speed_s & ctrl_r[`CTRL_SPEED_BIT];
    assign crs_nxt = crs_s | cfg29_r[`CFG29_CRS_BIT];
    assign ser_nxt = ser_s | cfg30_r[`CFG30_SERIAL_BIT];
    assign carin_nxt = carin_s | cfg29_r[`CFG29_CARRIER_BIT];
    assign codec_nxt = codec_s | cfg29_r[`CFG29_CODEC_BIT];
    assign scr_nxt = scr_s | cfg29_r[`CFG29_SCRAMBLER_BIT];
    assign fiber_nxt = fiber_s | cfg29_r[`CFG29_FIBER_BIT];

    logic an_r;
    logic restart_r;
    logic fdup_r;
    logic speed_r;
    logic crs_r;
    logic ser_r;
    logic carin_r;
    logic codec_r;
    logic scr_r;
    logic fiber_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            an_d_r <= 1'b0;
            an_r <= 1'b0;
            restart_r <= 1'b0;
            fdup_r <= 1'b0;
            speed_r <= 1'b0;
            crs_r <= 1'b0;
            ser_r <= 1'b0;
            carin_r <= 1'b0;
            codec_r <= 1'b0;
            scr_r <= 1'b0;
            fiber_r <= 1'b0;
        end else begin
            an_d_r <= an_s;
            an_r <= an_nxt;
            restart_r <= restart_nxt;
            fdup_r <= fdup_nxt;
            speed_r <= speed_nxt;
            crs_r <= crs_nxt;
            ser_r <= ser_nxt;
            carin_r <= carin_nxt;
            codec_r <= codec_nxt;
            scr_r <= scr_nxt;
            fiber_r <= fiber_nxt;
        end
    end

    assign o_autoneg_enable = an_r;
    assign o_autoneg_restart = restart_r;
    assign o_full_duplex = fdup_r;
    assign o_speed_100 = speed_r;
    assign o_carrier_sense_rx_only = crs_r;
    assign o_serial_mode = ser_r;
    assign o_carrier_integrity_enable = carin_r;
    assign o_codec_bypass = codec_r;
    assign o_scrambler_bypass = scr_r;
    assign o_fiber_mode = fiber_r;

    // ----------------------------------------
    // Station address and timer speedup
    // ----------------------------------------
    logic [4:0] addr_r;
    logic match_r;
    logic [8:0] scale_nxt;
    logic [8:0] scale_r;
    logic unsup_r;
    speedup_code_t sel_code;

    assign sel_code = speedup_code_t'(sel_s);

    always_comb begin
        case (sel_code)
            SPD_X16: scale_nxt = `SCALE_X16;
            SPD_X64: scale_nxt = `SCALE_X64;
            SPD_X256: scale_nxt = `SCALE_X256;
            default: scale_nxt = `SCALE_X1;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            addr_r <= 5'h00;
            match_r <= 1'b0;
            scale_r <= `SCALE_X1;
            unsup_r <= 1'b0;
        end else begin
            addr_r <= addr_s;
            // exact match only, zero is no broadcast
            match_r <= (i_frame_phy_address == addr_s);
            // normal rate unless test input high
            scale_r <= test_s ? scale_nxt : `SCALE_X1;
            // flag the speedup where autoneg fails
            unsup_r <= test_s & (sel_code == SPD_X256);
        end
    end

    assign o_station_address = addr_r;
    assign o_address_match = match_r;
    assign o_timer_scale = scale_r;
    assign o_autoneg_unsupported = unsup_r;

    // ----------------------------------------
    // Enhanced link check
    // ----------------------------------------
    link_state_t lnk_r;
    link_state_t lnk_nxt;
    logic [4:0] viol_r;
    logic [4:0] viol_nxt;
    logic trip;

    assign trip = enh_s & i_manchester_violation & (viol_r == `VIOL_LAST);

    always_comb begin
        lnk_nxt = lnk_r;
        case (lnk_r)
            LNK_DOWN: begin
                if (i_link_raw) begin
                    lnk_nxt = LNK_UP;
                end
            end
            LNK_UP: begin
                if (!i_link_raw) begin
                    lnk_nxt = LNK_DOWN;
                end else if (trip) begin
                    lnk_nxt = LNK_TRIPPED;
                end
            end
            LNK_TRIPPED: begin
                // Stays down until the raw link drops, so a noisy line cannot flap
                if (!i_link_raw) begin
                    lnk_nxt = LNK_DOWN;
                end
            end
            default: lnk_nxt = LNK_DOWN;
        endcase
    end

    always_comb begin
        if (lnk_r != LNK_UP || !enh_s) begin
            viol_nxt = 5'h00;
        end else if (i_manchester_violation) begin
            viol_nxt = 5'(viol_r + 5'h01);
        end else begin
            viol_nxt = viol_r;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            lnk_r <= LNK_DOWN;
            viol_r <= 5'h00;
        end else begin
            lnk_r <= lnk_nxt;
            viol_r <= viol_nxt;
        end
    end

    assign o_link_up = (lnk_r == LNK_UP);

    assign status_word = {3'h0, test_s, unsup_r, (lnk_r == LNK_TRIPPED), o_link_up, fiber_r,
                          scr_r, codec_r, carin_r, ser_r, crs_r, speed_r, fdup_r, an_r};

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [2:0] warm_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            warm_r <= 3'h0;
        end else if (warm_r != `WARM_DONE) begin
            warm_r <= 3'(warm_r + 3'h1);
        end
    end

    a_autoneg_and_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |->
            (o_autoneg_enable == ($past(i_autoneg_strap, 3) && $past(ctrl_r[`CTRL_AUTONEG_BIT])))
    ) else $error("autoneg enable differs from strap AND bit");

    a_restart_edge_pulse: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |->
            (o_autoneg_restart == ($past(i_autoneg_strap, 3) && !$past(i_autoneg_strap, 4)))
    ) else $error("restart pulse not tied to strap rising edge");

    a_restart_single_cycle: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        o_autoneg_restart |=> !o_autoneg_restart
    ) else $error("restart pulse longer than one cycle");

    a_duplex_or_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> (o_full_duplex == (!o_autoneg_enable &&
            ($past(i_full_duplex_strap, 3) || $past(ctrl_r[`CTRL_DUPLEX_BIT]))))
    ) else $error("full duplex differs from forced OR merge");

    a_speed_and_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> (o_speed_100 == (!o_autoneg_enable &&
            $past(i_speed_strap, 3) && $past(ctrl_r[`CTRL_SPEED_BIT])))
    ) else $error("speed differs from forced AND merge");

    a_crs_or_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> (o_carrier_sense_rx_only ==
            ($past(i_carrier_sense_mode_strap, 3) || $past(cfg29_r[`CFG29_CRS_BIT])))
    ) else $error("carrier sense mode differs from OR merge");

    a_serial_or_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> (o_serial_mode ==
            ($past(i_serial_interface_strap, 3) || $past(cfg30_r[`CFG30_SERIAL_BIT])))
    ) else $error("serial mode differs from OR merge");

    a_bypass_or_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> (o_codec_bypass ==
            ($past(i_codec_bypass_strap, 3) || $past(cfg29_r[`CFG29_CODEC_BIT])))
    ) else $error("codec bypass differs from OR merge");

    a_scrambler_or_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> (o_scrambler_bypass ==
            ($past(i_scrambler_bypass_strap, 3) || $past(cfg29_r[`CFG29_SCRAMBLER_BIT])))
    ) else $error("scrambler bypass differs from OR merge");

    a_carrier_fiber_merge: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> ((o_carrier_integrity_enable ==
            ($past(i_carrier_integrity_strap, 3) || $past(cfg29_r[`CFG29_CARRIER_BIT]))) &&
            (o_fiber_mode == ($past(i_fiber_select_strap, 3) || $past(cfg29_r[`CFG29_FIBER_BIT]))))
    ) else $error("carrier integrity or fiber differs from OR merge");

    a_address_no_broadcast: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |->
            (o_address_match == ($past(i_frame_phy_address) == $past(i_station_address_strap, 3)))
    ) else $error("address match not an exact compare");

    a_timer_scale_code: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (warm_r == `WARM_DONE) |-> (o_timer_scale == (!$past(i_timer_test_enable, 3) ? `SCALE_X1 :
            ($past(i_timer_speedup_select, 3) == 2'h1) ? `SCALE_X16 :
            ($past(i_timer_speedup_select, 3) == 2'h2) ? `SCALE_X64 :
            ($past(i_timer_speedup_select, 3) == 2'h3) ? `SCALE_X256 : `SCALE_X1))
    ) else $error("timer scale wrong for select code");

    a_link_trip_count: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (o_link_up && enh_s && i_manchester_violation && (viol_r == `VIOL_LAST)) |=> !o_link_up
    ) else $error("link not dropped on 31st violation");

    a_link_no_early_trip: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        (o_link_up && (viol_r != `VIOL_LAST)) |=> (lnk_r != LNK_TRIPPED)
    ) else $error("link tripped before 31 violations");

    a_read_one_cycle: assert property (
        @(posedge i_ref_clk) disable iff (i_srst)
        !i_reg_rd |=> (o_reg_rd_data == 16'h0000)
    ) else $error("read data outside the answer cycle");

endmodule : phy_strap_config_merge

// *** verif/strap_source.sv ***
// Model of the surrounding logic that drives the strap pins
module strap_source (
    input wire logic i_ref_clk,
    input wire logic [8:0] i_levels,
    input wire logic [4:0] i_address,
    input wire logic i_test,
    input wire logic [1:0] i_select,
    input wire logic i_enhanced,
    output logic [8:0] o_levels = '0,
    output logic [4:0] o_address = '0,
    output logic o_test = 1'b0,
    output logic [1:0] o_select = '0,
    output logic o_enhanced = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Strap drivers
    // ----------------------------------------
    // registered levels, no autoneg at top speedup, test low by default
    always @(posedge i_ref_clk) begin
        o_levels <= {i_levels[8] & ~(i_test & (i_select == 2'b11)), i_levels[7:0]};
        o_address <= i_address;
        o_test <= i_test;
        o_select <= i_select;
        o_enhanced <= i_enhanced;
    end
endmodule : strap_source

// *** verif/phy_strap_config_merge_tb.sv ***
// Self-checking bench for the strap merge block
module phy_strap_config_merge_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic clk = 0, srst = 1, tst = 0, enh = 0, raw = 0, mv = 0, wr = 0, rd = 0;
    logic [8:0] lv = '0;
    logic [4:0] sa = '0, fa = '0, ra = '0;
    logic [1:0] sel = '0;
    logic [15:0] wd = '0, d;
    wire [8:0] st;
    wire [4:0] sta_s, sta;
    wire [1:0] sel_s;
    wire [15:0] rdata;
    wire [8:0] scale;
    wire tst_s, enh_s, an, rst_p, spd, mtch, unsup, link;
    wire [6:0] eff;
    int bad_count = 0, num_checks = 0, n;
    localparam logic [4:0] RA [7] = '{5'h1d, 5'h1d, 5'h1d, 5'h1d, 5'h1e, 5'h1d, 5'h00};
    localparam int RB [7] = '{0, 4, 6, 3, 1, 10, 8};

    initial forever #5 clk = ~clk;

    strap_source strap_source_inst (.i_ref_clk(clk), .i_levels(lv), .i_address(sa), .i_test(tst),
        .i_select(sel), .i_enhanced(enh), .o_levels(st), .o_address(sta_s), .o_test(tst_s),
        .o_select(sel_s), .o_enhanced(enh_s));

    phy_strap_config_merge phy_strap_config_merge_inst (.i_ref_clk(clk), .i_srst(srst),
        .i_autoneg_strap(st[8]), .i_speed_strap(st[7]), .i_full_duplex_strap(st[6]),
        .i_carrier_sense_mode_strap(st[5]), .i_serial_interface_strap(st[4]),
        .i_carrier_integrity_strap(st[3]), .i_codec_bypass_strap(st[2]),
        .i_scrambler_bypass_strap(st[1]), .i_fiber_select_strap(st[0]),
        .i_station_address_strap(sta_s), .i_timer_test_enable(tst_s), .i_timer_speedup_select(sel_s),
        .i_enhanced_link_check_enable(enh_s), .i_link_raw(raw), .i_manchester_violation(mv),
        .i_frame_phy_address(fa), .i_reg_addr(ra), .i_reg_wr_data(wd), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rd_data(rdata), .o_autoneg_enable(an), .o_autoneg_restart(rst_p), .o_full_duplex(eff[6]),
        .o_speed_100(spd), .o_carrier_sense_rx_only(eff[5]), .o_serial_mode(eff[4]),
        .o_carrier_integrity_enable(eff[3]), .o_codec_bypass(eff[2]), .o_scrambler_bypass(eff[1]),
        .o_fiber_mode(eff[0]), .o_station_address(sta), .o_address_match(mtch), .o_timer_scale(scale),
        .o_autoneg_unsupported(unsup), .o_link_up(link));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task summarize;
        if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task reg_wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        ra <= a;
        wd <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : reg_rd

    // Partner flop plus three design edges, with margin
    task settle;
        repeat (6) @(posedge clk);
        #1;
    endtask : settle

    task viol(input int k);
        repeat (k) begin
            @(posedge clk);
            mv <= 1'b1;
            @(posedge clk);
            mv <= 1'b0;
        end
        @(posedge clk);
        #1;
    endtask : viol

    task wait_up;
        for (int i = 0; i < 10 && link !== 1'b1; i++) @(posedge clk);
        #1 chk_bit("link_up_wait", 1'b1, link);
        if (link !== 1'b1) summarize;
    endtask : wait_up

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1 chk_word("scale_reset", 16'h0001, {7'h0, scale});
        reg_rd(5'h00, d); chk_word("ctrl", 16'h3000, d);
        reg_rd(5'h1d, d); chk_word("cfg29", 16'h0000, d);
        reg_rd(5'h05, d); chk_word("unmapped", 16'h0000, d);
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            lv <= 9'h001 << k;
            settle; chk_word("or_strap", 16'h0001 << k, {9'h0, eff});
            lv <= '0;
            reg_wr(RA[k], (RA[k] == 5'h00 ? 16'h3000 : 16'h0000) | (16'h0001 << RB[k]));
            settle; chk_word("or_reg", 16'h0001 << k, {9'h0, eff});
            reg_wr(RA[k], RA[k] == 5'h00 ? 16'h3000 : 16'h0000);
            settle; chk_word("or_none", 16'h0000, {9'h0, eff});
        end
        @(posedge clk);
        lv <= 9'h1c0;
        n = 0;
        repeat (8) begin
            @(posedge clk);
            #1 if (rst_p === 1'b1) n++;
        end
        chk_word("restart_pulses", 16'h0001, 16'(n));
        settle; chk_word("an_on", 16'h0004, {13'h0, an, eff[6], spd});
        reg_wr(5'h00, 16'h2000);
        settle; chk_word("an_off", 16'h0003, {13'h0, an, eff[6], spd});
        reg_wr(5'h00, 16'h0000);
        settle; chk_word("speed_and", 16'h0002, {13'h0, an, eff[6], spd});
        reg_wr(5'h00, 16'h3000);
        lv <= '0;
        sa <= 5'h00;
        settle; chk_word("addr_zero", 16'h0001, {10'h0, sta, mtch});
        fa <= 5'h01;
        settle; chk_bit("addr_miss", 1'b0, mtch);
        sa <= 5'h15;
        fa <= 5'h15;
        settle; chk_word("addr_set", 16'h002b, {10'h0, sta, mtch});
        sel <= 2'b11;
        settle; chk_word("test_off", 16'h0002, {6'h0, scale, unsup});
        for (int c = 0; c < 4; c++) begin
            tst <= 1'b1;
            sel <= 2'(c);
            settle; chk_word("scale", {7'h0, c == 0 ? 9'h001 : 9'h001 << (2 * c + 2)}, {7'h0, scale});
            chk_bit("unsupported", c == 3, unsup);
        end
        tst <= 1'b0;
        raw <= 1'b1;
        enh <= 1'b1;
        settle; wait_up;
        viol(30); chk_bit("link_30", 1'b1, link);
        viol(1); chk_bit("link_31", 1'b0, link);
        reg_wr(5'h1f, 16'hffff);
        reg_rd(5'h1f, d); chk_word("status_trip", 16'h0400, d);
        raw <= 1'b0;
        settle;
        raw <= 1'b1;
        enh <= 1'b0;
        settle; wait_up;
        viol(40); chk_bit("link_plain", 1'b1, link);
        reg_wr(5'h1e, 16'h0002);
        reg_rd(5'h1e, d); chk_word("cfg30", 16'h0002, d);
        @(posedge clk);
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        reg_rd(5'h1e, d); chk_word("cfg30_reset", 16'h0000, d);
        reg_rd(5'h00, d); chk_word("ctrl_reset", 16'h3000, d);
        summarize;
    end
endmodule : phy_strap_config_merge_tb
